// ### design/pasop_pkg.sv
// Package for the converter sample output port: widths, mode codes, latency.
// Assumes a single core clock domain that oversamples the encode clock pins.
package pasop_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int unsigned SAMPLE_WIDTH = 11;
    localparam int unsigned PIPE_LATENCY = 5;
    localparam logic [2:0] PIPE_LATENCY_CNT = 3'h5;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_RESET = 11'h000;
    localparam logic [SAMPLE_WIDTH-1:0] MSB_MASK = 11'h400;
    localparam int unsigned MSB_POS = 10;

    // ------------------------------------------------------------
    // Format selector levels (0V, 1/3, 2/3, full supply)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PASOP_SEL_ZERO = 2'h0,
        PASOP_SEL_THIRD = 2'h1,
        PASOP_SEL_TWO_THIRDS = 2'h2,
        PASOP_SEL_FULL = 2'h3
    } pasop_sel_t;

    typedef enum logic [1:0] {
        PASOP_PWR_ACTIVE,
        PASOP_PWR_HIZ,
        PASOP_PWR_NAP,
        PASOP_PWR_SLEEP
    } pasop_pwr_t;

    // One captured sample travelling down the pipeline
    typedef struct packed {
        logic [SAMPLE_WIDTH-1:0] code;
        logic overflow;
    } pasop_sample_t;

endpackage

// ### design/pasop_sync.sv
// Two flip-flop synchroniser for a bus of levels.
// Assumes inputs are asynchronous to i_core_clk.
`timescale 1ns/10ps
`default_nettype none
module pasop_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ### design/pasop_pipe.sv
// Five-entry result pipeline advanced once per encode rising edge.
// Assumes i_adv is a one-cycle pulse on i_core_clk.
`timescale 1ns/10ps
`default_nettype none
module pasop_pipe (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Stream
    input wire logic i_adv,
    input wire pasop_pkg::pasop_sample_t i_sample,
    output pasop_pkg::pasop_sample_t o_sample
);
    pasop_pkg::pasop_sample_t stage [pasop_pkg::PIPE_LATENCY];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < pasop_pkg::PIPE_LATENCY; i++) begin
                stage[i] <= '0;
            end
            o_sample <= '0;
        end else if (i_adv) begin
            stage[0] <= i_sample;
            for (int i = 1; i < pasop_pkg::PIPE_LATENCY; i++) begin
                stage[i] <= stage[i-1];
            end
            o_sample <= stage[pasop_pkg::PIPE_LATENCY-1];
        end
    end
endmodule
`default_nettype wire

// ### design/pasop_top.sv
// Digital side of an 11-bit pipelined sampling converter output port.
// Assumes the analog quantiser result arrives as a level bus; all pins
// are asynchronous to i_core_clk and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module pasop_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Encode clock legs
    input wire logic i_encode_pos_in,
    input wire logic i_encode_neg_in,
    // Converter core result (offset binary, raw)
    input wire logic [pasop_pkg::SAMPLE_WIDTH-1:0] i_analog_code,
    input wire logic i_analog_over,
    input wire logic i_analog_under,
    // Mode straps
    input wire logic i_power_down_select,
    input wire logic i_output_enable_n,
    input wire logic [1:0] i_format_select,
    // Output port
    output logic [pasop_pkg::SAMPLE_WIDTH-1:0] o_sample_word_bits,
    output logic [pasop_pkg::SAMPLE_WIDTH-1:0] o_sample_word_bits_oe,
    output logic o_range_overflow_flag,
    output logic o_range_overflow_flag_oe,
    output logic o_data_valid_clock,
    output logic o_data_valid_clock_oe,
    // Status
    output logic o_stabilizer_on,
    output logic o_twos_complement,
    output logic o_converting,
    output logic o_nap,
    output logic o_sleep
);
    localparam int unsigned SYNC_W = pasop_pkg::SAMPLE_WIDTH + 8;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] async_bus;
    logic [SYNC_W-1:0] sync_bus;
    logic enc_pos;
    logic enc_neg;
    logic over_s;
    logic under_s;
    logic pd_s;
    logic oe_n_s;
    logic [1:0] fmt_s;
    logic [pasop_pkg::SAMPLE_WIDTH-1:0] code_s;

    assign async_bus = {i_encode_pos_in, i_encode_neg_in, i_analog_over, i_analog_under,
        i_power_down_select, i_output_enable_n, i_format_select, i_analog_code};

    pasop_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(async_bus),
        .o_sync(sync_bus)
    );

    assign {enc_pos, enc_neg, over_s, under_s, pd_s, oe_n_s, fmt_s, code_s} = sync_bus;

    // ------------------------------------------------------------
    // Encode phase and edges
    // ------------------------------------------------------------
    logic enc_level;
    logic enc_prev;
    logic enc_rise;
    logic enc_fall;

    // Legs equal keeps the previous phase, avoiding chatter at the crossing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            enc_level <= 1'b0;
        end else if (enc_pos && !enc_neg) begin
            enc_level <= 1'b1;
        end else if (!enc_pos && enc_neg) begin
            enc_level <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            enc_prev <= 1'b0;
        end else begin
            enc_prev <= enc_level;
        end
    end

    assign enc_rise = enc_level && !enc_prev;
    assign enc_fall = !enc_level && enc_prev;

    // ------------------------------------------------------------
    // Power mode decode
    // ------------------------------------------------------------
    pasop_pkg::pasop_pwr_t pwr_mode;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pwr_mode <= pasop_pkg::PASOP_PWR_HIZ;
        end else begin
            unique case ({pd_s, oe_n_s})
                2'b00: pwr_mode <= pasop_pkg::PASOP_PWR_ACTIVE;
                2'b01: pwr_mode <= pasop_pkg::PASOP_PWR_HIZ;
                2'b10: pwr_mode <= pasop_pkg::PASOP_PWR_NAP;
                2'b11: pwr_mode <= pasop_pkg::PASOP_PWR_SLEEP;
            endcase
        end
    end

    logic running;
    logic drive;
    assign running = (pwr_mode == pasop_pkg::PASOP_PWR_ACTIVE) ||
        (pwr_mode == pasop_pkg::PASOP_PWR_HIZ);
    assign drive = (pwr_mode == pasop_pkg::PASOP_PWR_ACTIVE);

    // ------------------------------------------------------------
    // Format and stabiliser
    // ------------------------------------------------------------
    logic twos;
    logic stab;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            twos <= 1'b0;
            stab <= 1'b0;
        end else begin
            unique case (pasop_pkg::pasop_sel_t'(fmt_s))
                pasop_pkg::PASOP_SEL_ZERO: begin
                    twos <= 1'b0;
                    stab <= 1'b0;
                end
                pasop_pkg::PASOP_SEL_THIRD: begin
                    twos <= 1'b0;
                    stab <= 1'b1;
                end
                pasop_pkg::PASOP_SEL_TWO_THIRDS: begin
                    twos <= 1'b1;
                    stab <= 1'b1;
                end
                pasop_pkg::PASOP_SEL_FULL: begin
                    twos <= 1'b1;
                    stab <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Track and capture
    // ------------------------------------------------------------
    pasop_pkg::pasop_sample_t track;
    pasop_pkg::pasop_sample_t held;

    // Track follows the input only while encode is low
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            track <= '0;
        end else if (!enc_level) begin
            track.code <= code_s;
            track.overflow <= over_s || under_s;
        end
    end

    // Format applied at capture so a selector change affects new samples only
    always_comb begin
        held.code = track.code ^ (twos ? pasop_pkg::MSB_MASK : pasop_pkg::SAMPLE_RESET);
        held.overflow = track.overflow;
    end

    logic adv;
    assign adv = enc_rise && running;

    // ------------------------------------------------------------
    // Pipeline of five encode cycles
    // ------------------------------------------------------------
    pasop_pkg::pasop_sample_t out_sample;

    pasop_pipe u_pipe (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_adv(adv),
        .i_sample(held),
        .o_sample(out_sample)
    );

    // ------------------------------------------------------------
    // Data valid clock: high with each new word, low on encode fall
    // ------------------------------------------------------------
    logic dv_clk;

    // Word changes one cycle after the rising data-valid edge and stands
    // across the fall, so a receiver latching on the fall sees a settled word
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dv_clk <= 1'b0;
        end else if (adv) begin
            dv_clk <= 1'b1;
        end else if (enc_fall && running) begin
            dv_clk <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_sample_word_bits <= pasop_pkg::SAMPLE_RESET;
            o_range_overflow_flag <= 1'b0;
        end else begin
            o_sample_word_bits <= out_sample.code;
            o_range_overflow_flag <= out_sample.overflow;
        end
    end

    assign o_data_valid_clock = dv_clk;
    assign o_sample_word_bits_oe = {pasop_pkg::SAMPLE_WIDTH{drive}};
    assign o_range_overflow_flag_oe = drive;
    assign o_data_valid_clock_oe = drive;
    assign o_stabilizer_on = stab;
    assign o_twos_complement = twos;
    assign o_converting = running;
    assign o_nap = (pwr_mode == pasop_pkg::PASOP_PWR_NAP);
    assign o_sleep = (pwr_mode == pasop_pkg::PASOP_PWR_SLEEP);
endmodule
`default_nettype wire

// ### test/pasop_props.sv
// Checker for the converter output port.
// Sees only pasop_top ports; bound below.
`timescale 1ns/10ps
`default_nettype none
module pasop_props (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Pins
    input wire logic i_encode_pos_in,
    input wire logic i_encode_neg_in,
    input wire logic i_power_down_select,
    input wire logic i_output_enable_n,
    // Outputs
    input wire logic [pasop_pkg::SAMPLE_WIDTH-1:0] o_sample_word_bits,
    input wire logic [pasop_pkg::SAMPLE_WIDTH-1:0] o_sample_word_bits_oe,
    input wire logic o_range_overflow_flag,
    input wire logic o_data_valid_clock,
    input wire logic o_data_valid_clock_oe,
    input wire logic o_converting,
    input wire logic o_nap,
    input wire logic o_sleep
);
    // ----
    // Checks
    // ----
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Pins pass 2 sync and 1 decode stage, so 5 steady samples are enough
    a_mode_active: assert property (
        (!i_power_down_select && !i_output_enable_n)[*5]
        |-> o_data_valid_clock_oe && (&o_sample_word_bits_oe) && o_converting)
        else $error("active mode not driving");
    a_mode_hiz: assert property (
        (!i_power_down_select && i_output_enable_n)[*5]
        |-> !o_data_valid_clock_oe && !(|o_sample_word_bits_oe) && o_converting)
        else $error("float mode wrong");
    a_mode_nap: assert property (
        (i_power_down_select && !i_output_enable_n)[*5]
        |-> o_nap && !o_sleep && !o_data_valid_clock_oe && !o_converting)
        else $error("nap mode wrong");
    a_mode_sleep: assert property (
        (i_power_down_select && i_output_enable_n)[*5]
        |-> o_sleep && !o_nap && !(|o_sample_word_bits_oe))
        else $error("sleep mode wrong");
    // Word register follows the clock rise by one cycle
    a_word_on_rise: assert property (
        $changed(o_sample_word_bits) && o_data_valid_clock_oe && $past(o_data_valid_clock_oe)
        |-> $past(o_data_valid_clock) && !$past(o_data_valid_clock, 2))
        else $error("word moved off clock rise");
    a_flag_on_rise: assert property (
        $changed(o_range_overflow_flag) && o_data_valid_clock_oe && $past(o_data_valid_clock_oe)
        |-> $past(o_data_valid_clock) && !$past(o_data_valid_clock, 2))
        else $error("flag moved off clock rise");
    a_rise_after_enc: assert property (
        $rose(o_data_valid_clock) && $past(o_data_valid_clock_oe)
        |-> $past(i_encode_pos_in, 3) && !$past(i_encode_neg_in, 3))
        else $error("clock rise without encode rise");
    a_fall_after_enc: assert property (
        $fell(o_data_valid_clock) && $past(o_data_valid_clock_oe)
        |-> !$past(i_encode_pos_in, 3) && $past(i_encode_neg_in, 3))
        else $error("clock fall without encode fall");
    c_fall: cover property ($fell(o_data_valid_clock));
    c_nap: cover property (o_nap);
    c_sleep: cover property (o_sleep);
endmodule
bind pasop_top pasop_props pasop_props_inst (.*);
`default_nettype wire

// ### test/pasop_rx.sv
// Capture model: latches word and flag on data-valid falls.
// Assumes i_idx is the bench's count of encode rises.
`timescale 1ns/10ps
`default_nettype none
module pasop_rx (
    // Clock
    input wire logic i_core_clk,
    // Port
    input wire pasop_pkg::pasop_sample_t i_word,
    input wire logic i_dv,
    input wire logic i_dv_oe,
    input wire logic [7:0] i_idx
);
    // ----
    // Capture
    // ----
    pasop_pkg::pasop_sample_t got [256];
    logic ok [256];
    logic dv_last = 1'b0;
    logic oe_last = 1'b0;
    int skip = 0;
    // Sampled mid-cycle so the word of the same edge has settled
    always @(negedge i_core_clk) begin
        if (i_dv_oe && !oe_last) begin
            skip = 5;
        end
        if (i_dv_oe && dv_last && !i_dv) begin
            if (skip > 0) begin
                skip--;
            end else begin
                got[i_idx] = i_word;
                ok[i_idx] = 1'b1;
            end
        end
        dv_last = i_dv;
        oe_last = i_dv_oe;
    end
endmodule
`default_nettype wire

// ### test/tb_pasop_top.sv
// Bench for the converter output port.
// Drives pins 2 ns after a rising core edge; pasop_rx reads the port.
`timescale 1ns/10ps
`default_nettype none
module tb_pasop_top;
    // ----
    // Signals
    // ----
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic encode_clock = 1'b0;
    logic [10:0] code = 11'h000;
    logic ovr = 1'b0;
    logic und = 1'b0;
    logic pd = 1'b0;
    logic oe_n = 1'b0;
    logic [1:0] fmt = 2'h0;
    pasop_pkg::pasop_sample_t word;
    logic [10:0] word_code;
    logic word_of;
    logic [10:0] word_oe;
    logic of_oe, dv, dv_oe, stab, tc, conv, nap, slp;
    pasop_pkg::pasop_sample_t cap [256];
    int rises = 0;
    int errors = 0;
    int n_compared = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    assign word = {word_code, word_of};
    pasop_top pasop_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_encode_pos_in(encode_clock), .i_encode_neg_in(~encode_clock), .i_analog_code(code),
        .i_analog_over(ovr), .i_analog_under(und), .i_power_down_select(pd),
        .i_output_enable_n(oe_n), .i_format_select(fmt), .o_sample_word_bits(word_code),
        .o_sample_word_bits_oe(word_oe), .o_range_overflow_flag(word_of),
        .o_range_overflow_flag_oe(of_oe), .o_data_valid_clock(dv),
        .o_data_valid_clock_oe(dv_oe), .o_stabilizer_on(stab), .o_twos_complement(tc),
        .o_converting(conv), .o_nap(nap), .o_sleep(slp));
    pasop_rx pasop_rx_inst (.i_core_clk(i_core_clk), .i_word(word), .i_dv(dv),
        .i_dv_oe(dv_oe), .i_idx(rises[7:0]));
    // ----
    // Tasks
    // ----
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #2;
    endtask
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One 200 ns encode period; a decoy value first shows tracking
    task automatic enc_cycle(input logic [10:0] c, input logic o, input logic u);
        code = ~c;
        tick(1);
        code = c;
        ovr = o;
        und = u;
        tick(1);
        encode_clock = 1'b1;
        rises++;
        cap[rises[7:0]] = {c ^ (fmt[1] ? pasop_pkg::MSB_MASK : 11'h000), o | u};
        tick(4);
        encode_clock = 1'b0;
        tick(2);
    endtask
    task automatic t_stream(input logic [1:0] f);
        int base;
        base = rises;
        fmt = f;
        tick(4);
        for (int k = 0; k < 12; k++) begin
            enc_cycle(k == 3 ? 11'h7FF : 11'(k * 173), k == 3, k == 0);
        end
        check(tc, fmt[1]);
        check(stab, fmt[0] ^ fmt[1]);
        check(pasop_rx_inst.ok[rises], 1'b1);
        for (int r = base + 1; r <= rises; r++) begin
            if (pasop_rx_inst.ok[r] === 1'b1) begin
                // Fall of cycle n is latched once cycle n+1 has been counted
                check(pasop_rx_inst.got[r], cap[r - 6]);
            end
        end
    endtask
    task automatic t_power;
        for (int m = 0; m < 4; m++) begin
            pd = m[1];
            oe_n = m[0];
            tick(6);
            check({dv_oe, of_oe, &word_oe, |word_oe}, {4{m == 0}});
            check({conv, nap, slp}, {!m[1], m == 2, m == 3});
        end
        pd = 1'b0;
        oe_n = 1'b0;
        tick(6);
    endtask
    initial begin
        tick(10);
        i_rst = 1'b0;
        tick(6);
        for (int f = 0; f < 4; f++) begin
            t_stream(f[1:0]);
        end
        t_power();
        t_stream(2'h2);
        wrap_up();
    end
endmodule
`default_nettype wire
